//--- verilog/pbs_sleep_ctrl.sv
/*
  Control of a pipelined synchronous SRAM: write and select qualification,
  output enable around writes, and the sleep sequence.
  Assumes pins arrive synchronous to mclk except sleepRequest and outputEnable_n.
*/
//
// Contract
// (RULE_01) Write inputs count only when selected with processor strobe high.
// (RULE_02) Chip selects sampled only when either address strobe is asserted.
// (RULE_03) Output enable ignored once a write has begun.
// (RULE_04) Master starts no access in two cycles before sleep.
// (RULE_05) Master keeps strobes and writes negated in quiet and recovery windows.
// (RULE_06) Master does not trust read data after sleep request asserts.
// (RULE_07) On sleep the device deselects itself and stops driving outputs.
// (RULE_08) Asleep, internal clocked activity stops despite a running clock; the array read register still loads every mclk.
// (RULE_09) Asleep, no selection, read or write regardless of inputs.
// (RULE_10) Non-burst use ties strobes, advance and first select fixed.
// (RULE_11) Burst order select tied firmly high or low when unused.
// (RULE_12) After sleep release, nothing honoured until recovery time elapses.
// (RULE_13) Selected when first and third selects low, second high.
`timescale 1ns/100ps
`include "pbs_regs.svh"

module pbs_sleep_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Address and strobes
  input wire logic [`PBS_ADDR_W-1:0] address,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic burst_order_select,
  // Chip selects
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  // Write controls
  input wire logic [`PBS_LANES-1:0] lane_write_n,
  input wire logic write_qualify_n,
  input wire logic all_lanes_write_n,
  // Asynchronous controls
  input wire logic outputEnable_n,
  input wire logic sleep_request,
  // Data lanes
  input wire logic [`PBS_DATA_W-1:0] dataLanesIn,
  output logic [`PBS_DATA_W-1:0] dataLanesOut,
  output logic dataLanesOe,
  // Status
  output logic asleep
);

  pbs_pkg::pbs_state_t state_reg;
  pbs_pkg::pbs_state_t state_next;
  pbs_mem_if memPort();

  logic sleepSeen;
  logic active;
  logic strobe;
  logic selected;
  logic writeReq;
  logic [`PBS_LANES-1:0] laneWe;

  pbs_mem uMem (
    .mclk(mclk),
    .port(memPort.mem)
  );

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  // Sleep pin is stable once stages two and three agree
  assign sleepSeen = (state_reg.syncSleep[1] == state_reg.syncSleep[2]) ?
    state_reg.syncSleep[2] : (state_reg.mode != pbs_pkg::PBS_NORMAL);
  // (RULE_09) Gate out sleep
  // (RULE_12) Gate out recovery
  assign active = (state_reg.mode == pbs_pkg::PBS_NORMAL) && !sleepSeen;
  // (RULE_02) Selects sampled on strobe
  assign strobe = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
  // (RULE_13) Select decode
  assign selected = active && strobe && !chip_select_a_n && chip_select_b &&
    !chip_select_c_n;
  // (RULE_01) Write qualification
  assign writeReq = selected && proc_addr_strobe_n &&
    (!all_lanes_write_n || (!write_qualify_n && (lane_write_n != 4'h0)) ||
    (!write_qualify_n && (lane_write_n == 4'h0)));

  genvar g;
  generate
    for (g = 0; g < `PBS_LANES; g = g + 1) begin : gWe
      assign laneWe[g] = writeReq && (!all_lanes_write_n || !lane_write_n[g]);
    end
  endgenerate

  // Array always follows the live address so back-to-back reads stay in order
  assign memPort.addr = address;
  assign memPort.laneWe = laneWe;
  assign memPort.wdata = dataLanesIn;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.syncSleep = {state_reg.syncSleep[1:0], sleep_request};
    state_next.readPend = 1'b0;
    case (state_reg.mode)
      pbs_pkg::PBS_NORMAL: begin
        if (sleepSeen) begin
          state_next.mode = pbs_pkg::PBS_QUIET;
          state_next.cnt = 2'(`PBS_ZZS_CYC - 1);
        end
      end
      pbs_pkg::PBS_QUIET: begin
        if (state_reg.cnt == 2'h0) begin
          state_next.mode = pbs_pkg::PBS_SLEEP;
        end else begin
          state_next.cnt = state_reg.cnt - 2'h1;
        end
      end
      pbs_pkg::PBS_SLEEP: begin
        if (!sleepSeen) begin
          state_next.mode = pbs_pkg::PBS_RECOVER;
          state_next.cnt = 2'(`PBS_ZZREC_CYC - 1);
        end
      end
      pbs_pkg::PBS_RECOVER: begin
        if (sleepSeen) begin
          state_next.mode = pbs_pkg::PBS_SLEEP;
        end else if (state_reg.cnt == 2'h0) begin
          state_next.mode = pbs_pkg::PBS_NORMAL;
        end else begin
          state_next.cnt = state_reg.cnt - 2'h1;
        end
      end
      default: begin
        state_next.mode = pbs_pkg::PBS_NORMAL;
      end
    endcase

    // Drivers turn on together with the data, never ahead of it
    if (state_reg.readPend) begin
      state_next.dataOut = memPort.rdata;
      state_next.outEn = 1'b1;
    end
    if (selected && !writeReq) begin
      state_next.readPend = 1'b1;
      state_next.readAddr = address;
    end else if (writeReq) begin
      // (RULE_03) Write forces outputs off
      state_next.outEn = 1'b0;
    end else if (active && strobe && !state_reg.readPend) begin
      // A read already in flight still finishes
      state_next.outEn = 1'b0;
    end
    // (RULE_07) Self-deselect in sleep
    // (RULE_08) Hold output pipe frozen
    if (state_reg.mode == pbs_pkg::PBS_SLEEP || state_next.mode == pbs_pkg::PBS_SLEEP) begin
      state_next.outEn = 1'b0;
      state_next.readPend = 1'b0;
      state_next.dataOut = state_reg.dataOut;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Output enable pin is asynchronous; it only gates the drivers
  assign dataLanesOut = state_reg.dataOut;
  assign dataLanesOe = state_reg.outEn && !outputEnable_n && !writeReq;
  assign asleep = (state_reg.mode == pbs_pkg::PBS_SLEEP);

endmodule // pbs_sleep_ctrl

//--- include/pbs_regs.svh
/*
  Timing counts and field widths for the pipelined burst SRAM sleep controller.
  Assumes a 10 MHz mclk; times are given in clock periods as printed.
*/
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH

// ------------------------------------------------------------
// Geometry
// ------------------------------------------------------------
`define PBS_ADDR_W 16
`define PBS_DATA_W 32
`define PBS_LANES 4
`define PBS_DEPTH 65536

// ------------------------------------------------------------
// Sleep timing, in clock periods or nanoseconds
// ------------------------------------------------------------
`define PBS_ZZS_PERIODS 2
`define PBS_ZZREC_PERIODS 2
`define PBS_CLK_PERIOD_NS 100
`define PBS_ZZQZ_NS 15
// Longest time rounds down, never below one cycle
`define PBS_ZZQZ_CYC ((`PBS_ZZQZ_NS / `PBS_CLK_PERIOD_NS) < 1 ? 1 : \
  (`PBS_ZZQZ_NS / `PBS_CLK_PERIOD_NS))
`define PBS_ZZS_CYC `PBS_ZZS_PERIODS
`define PBS_ZZREC_CYC `PBS_ZZREC_PERIODS
`define PBS_CNT_W 2

`endif

//--- include/pbs_pkg.sv
/*
  Types for the pipelined burst SRAM sleep controller.
  Assumes pbs_regs.svh is included before this package.
*/
`include "pbs_regs.svh"

package pbs_pkg;

  typedef enum logic [1:0] {
    PBS_NORMAL,
    PBS_QUIET,
    PBS_SLEEP,
    PBS_RECOVER
  } pbs_mode_t;

  typedef struct packed {
    pbs_mode_t mode;
    logic [`PBS_CNT_W-1:0] cnt;
    logic [2:0] syncSleep;
    logic readPend;
    logic [`PBS_ADDR_W-1:0] readAddr;
    logic outEn;
    logic [`PBS_DATA_W-1:0] dataOut;
  } pbs_state_t;

endpackage

//--- include/pbs_mem_if.sv
/*
  Carrier between the controller and its storage array.
  Assumes a single mclk domain shared by both ends.
*/
`timescale 1ns/100ps
`include "pbs_regs.svh"

interface pbs_mem_if;
  logic [`PBS_ADDR_W-1:0] addr;
  logic [`PBS_LANES-1:0] laneWe;
  logic [`PBS_DATA_W-1:0] wdata;
  logic [`PBS_DATA_W-1:0] rdata;

  modport ctrl (output addr, output laneWe, output wdata, input rdata);
  modport mem (input addr, input laneWe, input wdata, output rdata);
endinterface

//--- verilog/pbs_mem.sv
/*
  Byte-lane writable storage array; read data leave through a register.
  Assumes controller drives address and lane strobes on mclk.
*/
`timescale 1ns/100ps
`include "pbs_regs.svh"

module pbs_mem (
  // Clock
  input wire logic mclk,
  // Array port
  pbs_mem_if.mem port
);

  logic [`PBS_DATA_W-1:0] store [0:`PBS_DEPTH-1];
  logic [`PBS_DATA_W-1:0] rdataReg;

  // ------------------------------------------------------------
  // Lane writes
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PBS_LANES; g = g + 1) begin : gLane
      always_ff @(posedge mclk) begin
        if (port.laneWe[g]) begin
          store[port.addr][g*8 +: 8] <= port.wdata[g*8 +: 8];
        end
      end
    end
  endgenerate

  // No reset on the array: contents are undefined at power up anyway
  always_ff @(posedge mclk) begin
    rdataReg <= store[port.addr];
  end

  assign port.rdata = rdataReg;

endmodule // pbs_mem

//--- verification/pbs_sleep_ctrl_chk.sv
/* Pin assertions for pbs_sleep_ctrl; assumes one mclk domain, bound below. */
`timescale 1ns/100ps
`include "pbs_regs.svh"
module pbs_sleep_ctrl_chk (
  // Clock and inputs
  input wire logic mclk,
  input wire logic nrst,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic [`PBS_LANES-1:0] lane_write_n,
  input wire logic write_qualify_n,
  input wire logic all_lanes_write_n,
  input wire logic outputEnable_n,
  input wire logic sleep_request,
  // Outputs
  input wire logic dataLanesOe,
  input wire logic asleep
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [2:0] calm_reg;
  wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire wrIn = !all_lanes_write_n || (!write_qualify_n && lane_write_n != 4'hf);
  wire calm = calm_reg == 3'h7;
  wire rdReq = calm && sel && !outputEnable_n && (!proc_addr_strobe_n ||
    (!ctrl_addr_strobe_n && !wrIn));
  // Accesses near sleep are left unjudged
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) calm_reg <= 3'h0;
    else if (sleep_request || asleep) calm_reg <= 3'h0;
    else if (!calm) calm_reg <= calm_reg + 3'h1;
  end
  property p_read; rdReq |-> ##2 dataLanesOe; endproperty
  a_read: assert property (p_read) else $error("read not driven");
  property p_procWr; calm && sel && !proc_addr_strobe_n && wrIn && !outputEnable_n
    |-> ##2 dataLanesOe; endproperty
  a_procWr: assert property (p_procWr) else $error("write taken with proc strobe");
  property p_wrOe; calm && sel && proc_addr_strobe_n && !ctrl_addr_strobe_n && wrIn
    |-> !dataLanesOe ##1 !dataLanesOe; endproperty
  a_wrOe: assert property (p_wrOe) else $error("driving after write");
  property p_desel; calm && !sel && !(proc_addr_strobe_n && ctrl_addr_strobe_n)
    |-> ##3 !dataLanesOe; endproperty
  a_desel: assert property (p_desel) else $error("driving when deselected");
  property p_enter; $rose(sleep_request) |-> ##[3:8] asleep; endproperty
  a_enter: assert property (p_enter) else $error("sleep not reached");
  property p_quiet; asleep |-> !dataLanesOe; endproperty
  a_quiet: assert property (p_quiet) else $error("driving while asleep");
  property p_hold; asleep && sleep_request |=> asleep; endproperty
  a_hold: assert property (p_hold) else $error("left sleep early");
  property p_wake; $fell(sleep_request) && asleep |-> ##[1:8] !asleep; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  c_read: cover property (rdReq);
  c_write: cover property (calm && sel && !ctrl_addr_strobe_n && wrIn);
  c_sleep: cover property ($rose(asleep));
endmodule // pbs_sleep_ctrl_chk
bind pbs_sleep_ctrl pbs_sleep_ctrl_chk u_pbs_sleep_ctrl_chk (.*);

//--- verification/pbs_master.sv
/* Bus master model for the pins; assumes one caller at a time. */
`timescale 1ns/100ps
`include "pbs_regs.svh"
module pbs_master (
  // Clock
  input wire logic mclk,
  // Pins toward the controller
  output logic proc_addr_strobe_n,
  output logic ctrl_addr_strobe_n,
  output logic chip_select_a_n,
  output logic chip_select_b,
  output logic chip_select_c_n,
  output logic [`PBS_ADDR_W-1:0] address,
  output logic [`PBS_DATA_W-1:0] dataLanesIn,
  output logic [`PBS_LANES-1:0] lane_write_n,
  output logic write_qualify_n,
  output logic all_lanes_write_n,
  output logic outputEnable_n,
  output logic sleep_request
);
  initial begin
    {proc_addr_strobe_n, ctrl_addr_strobe_n, all_lanes_write_n, write_qualify_n} = 4'hf;
    {chip_select_a_n, chip_select_b, chip_select_c_n, lane_write_n} = 7'h7f;
    {address, dataLanesIn, outputEnable_n, sleep_request} = '0;
  end
  // Code is global, qualify, lanes; all active low
  task automatic acc(input logic proc, input logic [5:0] code,
      input logic [`PBS_ADDR_W-1:0] a, input logic [`PBS_DATA_W-1:0] d, input logic [2:0] sel);
    @(posedge mclk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n} <= {!proc, proc};
    {chip_select_a_n, chip_select_b, chip_select_c_n} <= sel;
    {all_lanes_write_n, write_qualify_n, lane_write_n} <= code;
    {address, dataLanesIn} <= {a, d};
    @(posedge mclk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n} <= 2'h3;
    {all_lanes_write_n, write_qualify_n, lane_write_n} <= 6'h3f;
    dataLanesIn <= ~d;
  endtask
  task automatic stream(input logic [`PBS_ADDR_W-1:0] a0, input logic [`PBS_ADDR_W-1:0] a1);
    @(posedge mclk);
    {proc_addr_strobe_n, ctrl_addr_strobe_n, chip_select_a_n} <= 3'b100;
    address <= a0;
    @(posedge mclk);
    address <= a1;
    @(posedge mclk);
    ctrl_addr_strobe_n <= 1'b1;
  endtask
  // only called with bus idle, no data trusted
  task automatic setSleep(input logic v);
    @(posedge mclk);
    sleep_request <= v;
  endtask
endmodule // pbs_master

//--- verification/tb_pbs_sleep_ctrl.sv
/* Bench for pbs_sleep_ctrl; assumes pbs_master and bound checker. */
`timescale 1ns/100ps
`include "pbs_regs.svh"
`define CHECK(g, e) begin nCompared++; if ((g) !== (e)) begin nErrors++; \
  $display("FAIL %0t got %h want %h", $time, g, e); end end
module tb_pbs_sleep_ctrl;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic burst_advance_n = 1'b1;
  logic burst_order_select = 1'b0;
  logic proc_addr_strobe_n, ctrl_addr_strobe_n, chip_select_a_n, chip_select_b;
  logic chip_select_c_n, write_qualify_n, all_lanes_write_n, outputEnable_n;
  logic sleep_request, dataLanesOe, asleep;
  logic [`PBS_LANES-1:0] lane_write_n;
  logic [`PBS_ADDR_W-1:0] address;
  logic [`PBS_DATA_W-1:0] dataLanesIn, dataLanesOut;
  int nErrors = 0;
  int nCompared = 0;
  localparam logic [`PBS_ADDR_W-1:0] addrA = 16'h0012;
  localparam logic [`PBS_ADDR_W-1:0] addrB = 16'h0034;
  pbs_master u_pbs_master (.*);
  pbs_sleep_ctrl u_pbs_sleep_ctrl (.*);
  initial forever #50 mclk = ~mclk;
  task automatic rd(input logic [`PBS_DATA_W-1:0] e);
    u_pbs_master.acc(1'b0, 6'h3f, addrA, 32'h0, 3'b010);
    repeat (2) @(posedge mclk);
    #1;
    `CHECK(dataLanesOe, 1'b1)
    `CHECK(dataLanesOut, e)
  endtask
  task automatic waitAsleep(input logic v);
    for (int i = 0; i < 20 && asleep !== v; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHECK(asleep, v)
  endtask
  task automatic tWrite;
    u_pbs_master.acc(1'b0, 6'h1f, addrA, 32'h1234_5678, 3'b010);
    rd(32'h1234_5678);
    u_pbs_master.acc(1'b0, 6'h2a, addrA, 32'haabb_ccdd, 3'b010);
    rd(32'h12bb_56dd);
  endtask
  task automatic tProcWr;
    u_pbs_master.acc(1'b1, 6'h20, addrA, 32'h0bad_0bad, 3'b010);
    rd(32'h12bb_56dd);
  endtask
  task automatic tDesel;
    for (int i = 0; i < 3; i++) begin
      u_pbs_master.acc(1'b0, 6'h20, addrA, 32'h0, 3'b010 ^ (3'b001 << i));
      repeat (2) @(posedge mclk);
      #1;
      `CHECK(dataLanesOe, 1'b0)
    end
    rd(32'h12bb_56dd);
  endtask
  task automatic tNonBurst;
    u_pbs_master.acc(1'b0, 6'h1f, addrB, 32'hcafe_f00d, 3'b010);
    u_pbs_master.stream(addrA, addrB);
    #1;
    `CHECK(dataLanesOut, 32'h12bb_56dd)
    @(posedge mclk);
    #1;
    `CHECK(dataLanesOut, 32'hcafe_f00d)
    `CHECK(dataLanesOe, 1'b1)
  endtask
  task automatic tSleep;
    u_pbs_master.setSleep(1'b1);
    waitAsleep(1'b1);
    `CHECK(dataLanesOe, 1'b0)
    u_pbs_master.acc(1'b0, 6'h1f, addrA, 32'h0bad_0bad, 3'b010);
    repeat (4) @(posedge mclk);
    #1;
    `CHECK(asleep, 1'b1)
    u_pbs_master.setSleep(1'b0);
    waitAsleep(1'b0);
    repeat (4) @(posedge mclk);
    rd(32'h12bb_56dd);
  endtask
  task automatic giveVerdict;
    $display("errors %0d compared %0d", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    tWrite;
    tProcWr;
    tDesel;
    tNonBurst;
    tSleep;
    giveVerdict;
  end
  // Run takes about 70 cycles; allow far more
  initial begin
    #400000;
    nErrors++;
    giveVerdict;
  end
endmodule // tb_pbs_sleep_ctrl
